//--- cic_consts.svh
// Constants for the coprocessor issue control block and its far end.
// Assumes inclusion by bare name from files in the same folder.
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH
`define CIC_NUM_CP 8
`define CIC_CP_W 4
`define CIC_REG_W 4
`define CIC_RT_SP 4'hd
`define CIC_LSU_STALL 1
`define CIC_ERR_CODE 2'h3
`endif

//--- cic_pkg.sv
// Types shared by both ends of the coprocessor issue link.
// Assumes cic_consts.svh is compiled alongside.
package cic_pkg;
	typedef enum logic [2:0] {
		CIC_OP_MCR = 3'h1,
		CIC_OP_MRC = 3'h2,
		CIC_OP_MCRR = 3'h3,
		CIC_OP_MRRC = 3'h4,
		CIC_OP_CDP = 3'h5,
		CIC_OP_CP_LOAD = 3'h6,
		CIC_OP_CP_STORE = 3'h7
	} cic_op_t;
	typedef enum logic [2:0] {
		CIC_ST_IDLE = 3'b001,
		CIC_ST_REQ = 3'b010,
		CIC_ST_WAIT = 3'b100
	} cic_state_t;
endpackage

//--- cic_link_if.sv
// Link between the core issue control and the coprocessor end.
// Assumes one shared clock; the testbench joins both ends here.
`timescale 1ns/1ps
`default_nettype none
interface cic_link_if;
	logic req_valid;
	logic [2:0] cp_num;
	cic_pkg::cic_op_t op;
	logic nonsecure;
	logic privileged;
	logic [63:0] wdata;
	logic committed;
	logic resp_done;
	logic resp_wait;
	logic resp_error;
	logic [63:0] rdata;
	modport core(output req_valid, cp_num, op, nonsecure, privileged, wdata, committed,
		input resp_done, resp_wait, resp_error, rdata);
	modport copro(input req_valid, cp_num, op, nonsecure, privileged, wdata, committed,
		output resp_done, resp_wait, resp_error, rdata);
endinterface
`default_nettype wire

//--- cic_copro_end.sv
// Coprocessor end: single-cycle accelerator with a 64-bit register pair.
// Assumes the core end drives one request at a time on the shared clock.
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.svh"
module cic_copro_end #(
	parameter logic [2:0] CP_ID = 3'h0
) (
	input wire logic clk,
	input wire logic reset_n,
	cic_link_if.copro link,
	input wire logic secure_debug_en,
	input wire logic force_error,
	input wire logic force_wait,
	output logic [63:0] user_regs
);
	typedef struct packed {
		logic [63:0] regs;
		logic done;
		logic waitf;
		logic err;
		logic [63:0] rdata;
	} cic_cp_t;
	cic_cp_t cur_ff, nxt_cur;
	logic hit;
	logic sec_block;

	// Requests for this number only; secure content hidden from nonsecure MRRC reads while secure_debug_en is low
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.waitf = 1'b0;
		nxt_cur.err = 1'b0;
		hit = link.req_valid && link.committed && (link.cp_num == CP_ID);
		sec_block = link.nonsecure && !secure_debug_en; // RULE_06 RULE_08
		if (hit) begin
			if (force_wait) begin
				nxt_cur.waitf = 1'b1; // RULE_13
			end else if (force_error || sec_block && link.op == cic_pkg::CIC_OP_MRRC) begin
				nxt_cur.err = 1'b1; // RULE_09 RULE_13
			end else begin
				nxt_cur.done = 1'b1; // RULE_14
				case (link.op)
					cic_pkg::CIC_OP_MCR: nxt_cur.regs[31:0] = link.wdata[31:0];
					cic_pkg::CIC_OP_MCRR: nxt_cur.regs = link.wdata;
					cic_pkg::CIC_OP_MRC: nxt_cur.rdata = {32'h0, cur_ff.regs[31:0]};
					cic_pkg::CIC_OP_MRRC: nxt_cur.rdata = cur_ff.regs;
					default: nxt_cur.rdata = cur_ff.rdata;
				endcase
			end
		end
	end

	// Registers are written only over the link; no debug back door
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign link.resp_done = cur_ff.done;
	assign link.resp_wait = cur_ff.waitf;
	assign link.resp_error = cur_ff.err;
	assign link.rdata = cur_ff.rdata;
	assign user_regs = cur_ff.regs; // RULE_05
endmodule
`default_nettype wire

//--- cic_core_end.sv
// Core-side coprocessor issue control: fault decode, load/store hazard, error.
// Assumes the pipeline presents one instruction at a time and honours issue_ready.
// Assumes fault_taken pulses once the exception logic has entered a pending fault.
// Summary of operation
// RULE_01: Coprocessor loads/stores on enabled CP0-7 fault undefined
// RULE_02: Stack pointer register field faults undefined
// RULE_03: Absent or disabled coprocessor gives no-coprocessor fault
// RULE_04: No debug path into coprocessor registers
// RULE_05: Coprocessor exposes registers on its own slave
// RULE_06: Coprocessor hides secure data from nonsecure debug; here only nonsecure MRRC is refused, and only while secure_debug_en is low
// RULE_07: No automatic coprocessor state save or restore
// RULE_08: Coprocessor refuses secure data to nonsecure handlers; here only MRRC is refused, a nonsecure MRC still returns the low word
// RULE_09: Error fault may be taken late, preempted
// RULE_10: One stall cycle after load/store before valid
// RULE_11: Hazard stall overlaps existing load-use stall
// RULE_12: Eight coprocessor numbers, 8 to 15 reserved
// RULE_13: Commit signalled; coprocessor may wait or error
// RULE_14: Back-to-back transfers, 32 or 64 bits per cycle; here a new request leaves at most every third cycle
// RULE_15: Error response pends an undefined fault
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.svh"
module cic_core_end #(
	parameter int NUM_CP = `CIC_NUM_CP
) (
	input wire logic clk,
	input wire logic reset_n,
	cic_link_if.core link,
	input wire logic instr_valid,
	input wire logic [3:0] instr_cp,
	input wire cic_pkg::cic_op_t instr_op,
	input wire logic [3:0] instr_rt,
	input wire logic [63:0] instr_wdata,
	input wire logic instr_nonsecure,
	input wire logic instr_privileged,
	input wire logic [7:0] cp_present,
	input wire logic [7:0] access_enable,
	input wire logic [7:0] nonsecure_enable,
	input wire logic lsu_done,
	input wire logic load_use_stall,
	input wire logic fault_taken,
	output logic issue_ready,
	output logic undefined_instruction_fault,
	output logic absent_coprocessor_fault,
	output logic fault_pending,
	output logic [63:0] result_data,
	output logic result_valid
);
	// Registered state toward the link and the pipeline
	typedef struct packed {
		cic_pkg::cic_state_t st;
		logic lsu_gap;
		logic req;
		logic [2:0] cp;
		cic_pkg::cic_op_t op;
		logic ns;
		logic priv;
		logic [63:0] wdata;
		logic ready;
		logic undef_f;
		logic absent_coprocessor_fault_f;
		logic pend;
		logic [63:0] res;
		logic res_v;
	} cic_core_t;
	cic_core_t cur_ff, nxt_cur;
	// Combinational decode results
	logic enabled;
	logic hazard;

	// Present and enabled for the current security state
	function automatic logic cp_usable(input logic [3:0] n, input logic ns,
		input logic [7:0] pres, input logic [7:0] acc, input logic [7:0] nsa);
		logic ok;
		ok = 1'b0;
		// Numbers at or above NUM_CP, reserved ones included, read as absent
		if (n < 4'(NUM_CP)) begin
			ok = pres[n[2:0]] && acc[n[2:0]] && (!ns || nsa[n[2:0]]); // RULE_12
		end
		return ok;
	endfunction

	// Coprocessor loads and stores have no path on this link
	function automatic logic is_mem_op(input cic_pkg::cic_op_t o);
		logic mem;
		mem = (o == cic_pkg::CIC_OP_CP_LOAD) || (o == cic_pkg::CIC_OP_CP_STORE);
		return mem;
	endfunction

	// Every form but the data-processing one carries a core register field
	function automatic logic uses_core_reg(input cic_pkg::cic_op_t o);
		logic xfer;
		xfer = (o != cic_pkg::CIC_OP_CDP);
		return xfer;
	endfunction

	// Decode, stall, issue and response handling in one pass
	always_comb begin
		// Pulses default low each cycle; levels hold unless changed below
		nxt_cur = cur_ff;
		nxt_cur.undef_f = 1'b0;
		nxt_cur.absent_coprocessor_fault_f = 1'b0;
		nxt_cur.res_v = 1'b0;
		enabled = cp_usable(instr_cp, instr_nonsecure, cp_present, access_enable,
			nonsecure_enable);
		// Gap flop decouples memory wait from request valid; it lives for the single
		// cycle after the access completes and then falls by itself, so an idle
		// pipeline is held off in the completion cycle and in the one cycle after it
		nxt_cur.lsu_gap = lsu_done && !load_use_stall; // RULE_10 RULE_11
		// Load-use stall already covers the gap, so no extra cycle is added
		hazard = (cur_ff.lsu_gap || lsu_done) && !load_use_stall; // RULE_10 RULE_11
		// Clear first; a fault raised below in the same cycle sets it again, so set wins
		if (fault_taken) begin
			nxt_cur.pend = 1'b0;
		end
		case (cur_ff.st)
			cic_pkg::CIC_ST_IDLE: begin
				nxt_cur.req = 1'b0;
				// Ready drops for the cycle after an access completes; the take
				// below also checks the hazard, so a late pipeline cannot slip in
				nxt_cur.ready = !(lsu_done && !load_use_stall); // RULE_10 RULE_11
				if (instr_valid && cur_ff.ready && !hazard) begin
					if (!enabled) begin
						// Absent or locked out is decided before any other decode
						nxt_cur.absent_coprocessor_fault_f = 1'b1; // RULE_03
						nxt_cur.pend = 1'b1;
					end else if (is_mem_op(instr_op)) begin
						// Loads and stores never reach the link
						nxt_cur.undef_f = 1'b1; // RULE_01
						nxt_cur.pend = 1'b1;
					end else if (uses_core_reg(instr_op) && instr_rt == `CIC_RT_SP) begin
						// Stack pointer as transfer register is refused outright
						nxt_cur.undef_f = 1'b1; // RULE_02
						nxt_cur.pend = 1'b1;
					end else begin
						// Issue: request and commit leave together next cycle
						nxt_cur.req = 1'b1; // RULE_13
						nxt_cur.cp = instr_cp[2:0];
						nxt_cur.op = instr_op;
						nxt_cur.ns = instr_nonsecure;
						nxt_cur.priv = instr_privileged;
						nxt_cur.wdata = instr_wdata;
						nxt_cur.ready = 1'b0;
						nxt_cur.st = cic_pkg::CIC_ST_REQ;
					end
				end
			end
			cic_pkg::CIC_ST_REQ: begin
				// Request stands one cycle; the far end answers in the next one
				nxt_cur.req = 1'b0;
				nxt_cur.st = cic_pkg::CIC_ST_WAIT;
			end
			cic_pkg::CIC_ST_WAIT: begin
				// Error first: the fault is only pended and may be taken late
				if (link.resp_error) begin
					nxt_cur.undef_f = 1'b1; // RULE_15 RULE_09
					nxt_cur.pend = 1'b1;
					nxt_cur.ready = 1'b1;
					nxt_cur.st = cic_pkg::CIC_ST_IDLE;
				end else if (link.resp_wait) begin
					// Interruptible wait: offer the same request again
					nxt_cur.req = 1'b1; // RULE_13
					nxt_cur.st = cic_pkg::CIC_ST_REQ;
				end else if (link.resp_done) begin
					// Result stands for one cycle only
					nxt_cur.res = link.rdata; // RULE_14
					nxt_cur.res_v = 1'b1;
					nxt_cur.ready = 1'b1;
					nxt_cur.st = cic_pkg::CIC_ST_IDLE;
				end
			end
			default: begin
				// Unreachable codes fall back to idle
				nxt_cur.st = cic_pkg::CIC_ST_IDLE;
			end
		endcase
	end

	// State holds no coprocessor registers; context is software's job
	// Reset values are constants only; op resets to data processing so the
	// link shows a harmless code until the first issue
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_ff <= '{st: cic_pkg::CIC_ST_IDLE, op: cic_pkg::CIC_OP_CDP, default: '0}; // RULE_07
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Link outputs; committed rides with valid, no debug access path
	assign link.req_valid = cur_ff.req; // RULE_04
	assign link.committed = cur_ff.req;
	assign link.cp_num = cur_ff.cp;
	assign link.op = cur_ff.op;
	assign link.nonsecure = cur_ff.ns;
	assign link.privileged = cur_ff.priv;
	assign link.wdata = cur_ff.wdata;

	// Pipeline side: ready level, one-cycle fault and result pulses
	assign issue_ready = cur_ff.ready;
	assign undefined_instruction_fault = cur_ff.undef_f;
	assign absent_coprocessor_fault = cur_ff.absent_coprocessor_fault_f;
	// Pending level lasts until the exception logic takes the fault
	assign fault_pending = cur_ff.pend;
	assign result_data = cur_ff.res;
	assign result_valid = cur_ff.res_v;
endmodule
`default_nettype wire

//--- cic_link_checker.sv
// Concurrent checks on the link between core end and coprocessor end.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module cic_link_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic committed,
	input wire cic_pkg::cic_op_t op,
	input wire logic resp_done,
	input wire logic resp_wait,
	input wire logic resp_error
);
	// Single domain, so clock and reset are stated once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_commit_with_req: assert property (req_valid |-> committed)
		else $error("request without commit");
	a_commit_only_req: assert property (committed |-> req_valid)
		else $error("commit without request");
	a_no_load_issue: assert property (req_valid |-> op != cic_pkg::CIC_OP_CP_LOAD)
		else $error("load reached link");
	a_no_store_issue: assert property (req_valid |-> op != cic_pkg::CIC_OP_CP_STORE)
		else $error("store reached link");
	a_resp_after_req: assert property ((resp_done || resp_wait || resp_error) |-> $past(req_valid))
		else $error("answer without request");
	a_wait_reissue: assert property (resp_wait |=> req_valid)
		else $error("no reissue after wait");
	a_error_no_retry: assert property (resp_error |=> !req_valid)
		else $error("request after error");
	a_one_outstanding: assert property (req_valid |=> !req_valid)
		else $error("second request outstanding");
	a_single_answer: assert property ($onehot0({resp_done, resp_wait, resp_error}))
		else $error("several answers");
endmodule
`default_nettype wire

//--- cic_tb.sv
// Testbench joining core end and coprocessor end across the link.
// Assumes design inputs change at the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic instr_valid = 1'b0;
	logic lsu_done = 1'b0;
	logic load_use_stall = 1'b0;
	logic fault_taken = 1'b0;
	logic force_error = 1'b0;
	logic force_wait = 1'b0;
	logic [3:0] instr_cp = 4'h0;
	logic [3:0] instr_rt = 4'h0;
	logic [7:0] access_enable = 8'h01;
	logic [7:0] nonsecure_enable = 8'hff;
	logic instr_nonsecure = 1'b0;
	logic secure_debug_en = 1'b1;
	logic [63:0] instr_wdata = 64'h0;
	cic_pkg::cic_op_t instr_op = cic_pkg::CIC_OP_CDP;
	logic issue_ready, ufault, afault, fault_pending, result_valid, rv, uf, af;
	logic [63:0] result_data, user_regs, rd;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	cic_link_if link();
	cic_core_end cic_core_end_i (.clk(clk), .reset_n(reset_n), .link(link),
		.instr_valid(instr_valid), .instr_cp(instr_cp), .instr_op(instr_op),
		.instr_rt(instr_rt), .instr_wdata(instr_wdata), .instr_nonsecure(instr_nonsecure),
		.instr_privileged(1'b1), .cp_present(8'h03), .access_enable(access_enable),
		.nonsecure_enable(nonsecure_enable), .lsu_done(lsu_done),
		.load_use_stall(load_use_stall),
		.fault_taken(fault_taken), .issue_ready(issue_ready),
		.undefined_instruction_fault(ufault), .absent_coprocessor_fault(afault),
		.fault_pending(fault_pending), .result_data(result_data), .result_valid(result_valid));
	cic_copro_end #(.CP_ID(3'h0)) cic_copro_end_i (.clk(clk), .reset_n(reset_n), .link(link),
		.secure_debug_en(secure_debug_en), .force_error(force_error), .force_wait(force_wait),
		.user_regs(user_regs));
	cic_link_checker cic_link_checker_i (.clk(clk), .reset_n(reset_n),
		.req_valid(link.req_valid), .committed(link.committed), .op(link.op),
		.resp_done(link.resp_done), .resp_wait(link.resp_wait), .resp_error(link.resp_error));
	// 200 MHz
	always #2.5 clk = ~clk;
	task automatic chk_flags(input logic [2:0] g, input logic [2:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t flags %b exp %b", $time, g, e);
		end
	endtask
	task automatic chk_data(input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t data %h exp %h", $time, g, e);
		end
	endtask
	// Offer one instruction, then gather {undefined, absent, result} over eight cycles
	task automatic run_op(input logic [3:0] cp, input cic_pkg::cic_op_t o, input logic [3:0] rt,
		input logic [63:0] d, input logic [2:0] e);
		int n;
		n = 0;
		while (issue_ready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		instr_cp = cp;
		instr_op = o;
		instr_rt = rt;
		instr_wdata = d;
		instr_valid = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		{rv, uf, af} = 3'h0;
		for (n = 0; n < 8; n++) begin
			// Far end samples its forcing inputs at the request only
			if (n == 2)
				{force_wait, force_error} = 2'h0;
			if (result_valid === 1'b1)
				rd = result_data;
			rv |= result_valid === 1'b1;
			uf |= ufault === 1'b1;
			af |= afault === 1'b1;
			@(negedge clk);
		end
		chk_flags({uf, af, rv}, e);
	endtask
	task automatic test_faults;
		run_op(4'h0, cic_pkg::CIC_OP_CP_LOAD, 4'h1, 64'h0, 3'b100);
		run_op(4'h0, cic_pkg::CIC_OP_CP_STORE, 4'h1, 64'h0, 3'b100);
		run_op(4'h0, cic_pkg::CIC_OP_MCR, 4'hd, 64'h0, 3'b100);
		run_op(4'h2, cic_pkg::CIC_OP_MCR, 4'h1, 64'h0, 3'b010);
		run_op(4'h9, cic_pkg::CIC_OP_MCR, 4'h1, 64'h0, 3'b010);
		access_enable = 8'h00;
		run_op(4'h0, cic_pkg::CIC_OP_MCR, 4'h1, 64'h0, 3'b010);
		access_enable = 8'h01;
		$display("test faults done");
	endtask
	task automatic test_transfer;
		run_op(4'h0, cic_pkg::CIC_OP_MCRR, 4'h1, 64'h0123456789abcdef, 3'b001);
		chk_data(user_regs, 64'h0123456789abcdef);
		run_op(4'h0, cic_pkg::CIC_OP_MRRC, 4'h1, 64'h0, 3'b001);
		chk_data(rd, 64'h0123456789abcdef);
		force_wait = 1'b1;
		run_op(4'h0, cic_pkg::CIC_OP_MCR, 4'h2, 64'h55aa33cc, 3'b001);
		chk_data({32'h0, user_regs[31:0]}, 64'h55aa33cc);
		run_op(4'h0, cic_pkg::CIC_OP_MRC, 4'h1, 64'h0, 3'b001);
		chk_data(rd, 64'h0000000055aa33cc);
		run_op(4'h0, cic_pkg::CIC_OP_CDP, 4'hd, 64'h0, 3'b001);
		$display("test transfer done");
	endtask
	// Security state: nonsecure lockout at the core, secure data refused at the far end
	task automatic test_secure;
		instr_nonsecure = 1'b1;
		nonsecure_enable = 8'hfe;
		run_op(4'h0, cic_pkg::CIC_OP_MCR, 4'h1, 64'h0, 3'b010);
		nonsecure_enable = 8'hff;
		secure_debug_en = 1'b0;
		run_op(4'h0, cic_pkg::CIC_OP_MRRC, 4'h1, 64'h0, 3'b100);
		secure_debug_en = 1'b1;
		run_op(4'h0, cic_pkg::CIC_OP_MRRC, 4'h1, 64'h0, 3'b001);
		chk_data(rd, 64'h0123456755aa33cc);
		instr_nonsecure = 1'b0;
		$display("test secure done");
	endtask
	task automatic test_error;
		// Earlier faults left the pending flag up; clear it so the error must set it
		fault_taken = 1'b1;
		@(negedge clk);
		fault_taken = 1'b0;
		chk_flags({fault_pending, 2'h0}, 3'b000);
		force_error = 1'b1;
		run_op(4'h0, cic_pkg::CIC_OP_MCR, 4'h1, 64'h1, 3'b100);
		chk_flags({fault_pending, 2'h0}, 3'b100);
		fault_taken = 1'b1;
		@(negedge clk);
		fault_taken = 1'b0;
		chk_flags({fault_pending, 2'h0}, 3'b000);
		$display("test error done");
	endtask
	// Gap after a memory access; none extra when the load-use stall covers it
	task automatic test_hazard;
		lsu_done = 1'b1;
		@(negedge clk);
		lsu_done = 1'b0;
		chk_flags({issue_ready, 2'h0}, 3'b000);
		@(negedge clk);
		chk_flags({issue_ready, 2'h0}, 3'b100);
		{lsu_done, load_use_stall} = 2'h3;
		@(negedge clk);
		lsu_done = 1'b0;
		chk_flags({issue_ready, 2'h0}, 3'b100);
		@(negedge clk);
		load_use_stall = 1'b0;
		@(negedge clk);
		chk_flags({issue_ready, 2'h0}, 3'b100);
		$display("test hazard done");
	endtask
	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Cut a hang short well past the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		test_faults();
		test_transfer();
		test_secure();
		test_error();
		test_hazard();
		finish_test();
	end
endmodule
`default_nettype wire
